/* File: hw/osf_trigger_fsm.sv */
// trigger sequencer with operation and questionable status groups
// assumes command strobes are one-cycle pulses on clk_sys; pins are async
`timescale 1ns/1ps
`include "osf_map.svh"
module osf_trigger_fsm (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_abort,
  input wire logic cmd_rst,
  input wire logic cmd_init_imm,
  input wire logic cmd_cont_on,
  input wire logic cmd_cont_off,
  input wire logic cmd_bus_trg,
  input wire logic cmd_trig_imm,
  input wire logic cmd_cfg_wr,
  input wire osf_pkg::osf_cfg_t cfg_in,
  input wire logic ext_trig_pin,
  input wire logic man_trig_pin,
  input wire osf_pkg::osf_stat_t stat_pin,
  input wire logic meas_done,
  input wire logic [15:0] oper_enable,
  input wire logic [15:0] ques_enable,
  input wire logic oper_event_read,
  input wire logic oper_event_clear,
  input wire logic ques_event_read,
  input wire logic ques_event_clear,
  output logic meas_start,
  output logic volt_on,
  output logic [15:0] operation_condition,
  output logic [15:0] operation_event,
  output logic [15:0] ques_condition,
  output logic [15:0] ques_event,
  output logic [7:0] stb_summary
);
  osf_pkg::osf_state_t state_r;
  osf_pkg::osf_state_t state_nxt;
  osf_pkg::osf_cfg_t cfg_r;
  logic cont_r;
  logic trig_imm_r;
  logic [23:0] dly_r;
  logic [15:0] cnt_r;
  logic [3:0] sub_r;
  logic measuring_r;
  logic [2:0] ext_sync_r;
  logic [2:0] man_sync_r;
  osf_pkg::osf_stat_t stat_s1_r;
  osf_pkg::osf_stat_t stat_s2_r;
  logic ext_edge;
  logic man_edge;
  logic arm_ev;
  logic trig_ev;
  logic [15:0] oper_cond;
  logic oper_sum;
  logic ques_sum;
  logic go_idle;

  function automatic logic src_event(input osf_pkg::osf_src_t src, input logic bus, input logic ext,
                                     input logic man);
    case (src)
      osf_pkg::OSF_SRC_BUS: src_event = bus;
      osf_pkg::OSF_SRC_EXT: src_event = ext;
      osf_pkg::OSF_SRC_MAN: src_event = man;
      default: src_event = 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ext_sync_r <= 3'h0;
      man_sync_r <= 3'h0;
      stat_s1_r <= '0;
      stat_s2_r <= '0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_trig_pin}; // RULE20
      man_sync_r <= {man_sync_r[1:0], man_trig_pin};
      stat_s1_r <= stat_pin;
      stat_s2_r <= stat_s1_r;
    end
  end
  assign ext_edge = ext_sync_r[1] & ~ext_sync_r[2];
  assign man_edge = man_sync_r[1] & ~man_sync_r[2];
  assign arm_ev = src_event(cfg_r.arm_src, cmd_bus_trg, ext_edge, man_edge); // RULE13 RULE21
  assign trig_ev = src_event(cfg_r.trig_src, cmd_bus_trg, ext_edge, man_edge); // RULE16
  assign go_idle = cmd_abort | cmd_rst; // RULE10

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_r <= '{osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, `OSF_DELAY_RESET, `OSF_DELAY_RESET, `OSF_COUNT_RESET};
      cont_r <= 1'b0;
    end else if (cmd_rst) begin
      cfg_r <= '{osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, `OSF_DELAY_RESET, `OSF_DELAY_RESET, `OSF_COUNT_RESET}; // RULE14 RULE18
      cont_r <= 1'b0; // RULE10
    end else begin
      if (cmd_cfg_wr) begin
        cfg_r <= cfg_in;
      end
      if (cmd_cont_on) begin
        cont_r <= 1'b1;
      end else if (cmd_cont_off) begin
        cont_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_imm_r <= 1'b0;
    end else if (go_idle) begin
      trig_imm_r <= 1'b0;
    end else if (cmd_trig_imm) begin
      trig_imm_r <= 1'b1; // RULE17
    end else if (state_r == osf_pkg::OSF_TRIG_DET) begin
      trig_imm_r <= 1'b0; // RULE17
    end
  end

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      osf_pkg::OSF_IDLE: begin
        if (cmd_init_imm || cont_r) begin
          state_nxt = osf_pkg::OSF_INIT; // RULE11
        end
      end
      osf_pkg::OSF_INIT: state_nxt = osf_pkg::OSF_ARM_DET; // RULE12
      osf_pkg::OSF_ARM_DET: begin
        if (cfg_r.arm_src == osf_pkg::OSF_SRC_IMM) begin
          state_nxt = osf_pkg::OSF_TRIG_DET; // RULE13
        end else if (arm_ev) begin
          state_nxt = osf_pkg::OSF_ARM_DLY;
        end
      end
      osf_pkg::OSF_ARM_DLY: begin
        if (dly_r == 24'h000000) begin
          state_nxt = osf_pkg::OSF_VOLT_ON; // RULE14
        end
      end
      osf_pkg::OSF_VOLT_ON: begin
        if (sub_r == 4'h0) begin
          state_nxt = osf_pkg::OSF_ARM_WAIT; // RULE13
        end
      end
      osf_pkg::OSF_ARM_WAIT: begin
        if (sub_r == 4'h0) begin
          state_nxt = osf_pkg::OSF_TRIG_DET; // RULE15
        end
      end
      osf_pkg::OSF_TRIG_DET: begin
        if (trig_imm_r) begin
          state_nxt = osf_pkg::OSF_SEQ_OP; // RULE17
        end else if (trig_ev) begin
          state_nxt = osf_pkg::OSF_TRIG_DLY; // RULE16
        end
      end
      osf_pkg::OSF_TRIG_DLY: begin
        if (dly_r == 24'h000000) begin
          state_nxt = osf_pkg::OSF_SEQ_OP; // RULE14
        end
      end
      osf_pkg::OSF_SEQ_OP: begin
        if (meas_done) begin
          if (cnt_r > 16'h0001) begin
            state_nxt = osf_pkg::OSF_TRIG_DET; // RULE18
          end else if (cont_r) begin
            state_nxt = osf_pkg::OSF_TRIG_DET; // RULE12
          end else begin
            state_nxt = osf_pkg::OSF_IDLE; // RULE12
          end
        end
      end
      default: state_nxt = osf_pkg::OSF_IDLE;
    endcase
    if (go_idle) begin
      state_nxt = osf_pkg::OSF_IDLE; // RULE10
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= osf_pkg::OSF_IDLE; // RULE10
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // delay, sub-state and count timers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dly_r <= `OSF_DELAY_RESET;
    end else if (state_nxt == osf_pkg::OSF_ARM_DLY && state_r != osf_pkg::OSF_ARM_DLY) begin
      dly_r <= cfg_r.arm_delay; // RULE14
    end else if (state_nxt == osf_pkg::OSF_TRIG_DLY && state_r != osf_pkg::OSF_TRIG_DLY) begin
      dly_r <= cfg_r.trig_delay; // RULE14
    end else if (dly_r != 24'h000000) begin
      dly_r <= dly_r - 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sub_r <= 4'h0;
    end else if (state_nxt == osf_pkg::OSF_VOLT_ON && state_r != osf_pkg::OSF_VOLT_ON) begin
      sub_r <= `OSF_VON_CYCLES;
    end else if (state_nxt == osf_pkg::OSF_ARM_WAIT && state_r != osf_pkg::OSF_ARM_WAIT) begin
      sub_r <= `OSF_WAIT_CYCLES;
    end else if (sub_r != 4'h0) begin
      sub_r <= sub_r - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= `OSF_COUNT_RESET;
    end else if (state_r == osf_pkg::OSF_INIT || state_nxt == osf_pkg::OSF_IDLE) begin
      cnt_r <= cfg_r.trig_count; // RULE18
    end else if (state_r == osf_pkg::OSF_SEQ_OP && meas_done) begin
      cnt_r <= (cnt_r > 16'h0001) ? cnt_r - 16'h0001 : cfg_r.trig_count; // RULE18
    end
  end

  // ----------------------------------------
  // measurement handshake
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meas_start <= 1'b0;
      measuring_r <= 1'b0;
      volt_on <= 1'b0;
    end else begin
      meas_start <= state_nxt == osf_pkg::OSF_SEQ_OP && state_r != osf_pkg::OSF_SEQ_OP; // RULE19
      measuring_r <= state_nxt == osf_pkg::OSF_SEQ_OP; // RULE19
      volt_on <= (volt_on | (state_nxt == osf_pkg::OSF_VOLT_ON)) & (state_nxt != osf_pkg::OSF_IDLE);
    end
  end

  // ----------------------------------------
  // status groups
  // ----------------------------------------
  always_comb begin
    oper_cond = 16'h0000; // RULE5
    oper_cond[`OSF_BIT_BUFFULL] = stat_s2_r.data_buffer_full; // RULE5
    oper_cond[`OSF_BIT_CORR] = stat_s2_r.correcting; // RULE6
    oper_cond[`OSF_BIT_WARM] = state_r == osf_pkg::OSF_ARM_DET; // RULE7
    oper_cond[`OSF_BIT_WTRIG] = state_r == osf_pkg::OSF_TRIG_DET; // RULE7
    oper_cond[`OSF_BIT_MEAS] = measuring_r; // RULE6
    oper_cond[`OSF_BIT_RANGE] = stat_s2_r.ranging; // RULE8
    oper_cond[`OSF_BIT_SETTLE] = stat_s2_r.settling; // RULE8
    oper_cond[`OSF_BIT_CAL] = stat_s2_r.calibrating; // RULE8
  end

  osf_status_group u_oper (
    .clk_sys(clk_sys),
    .reset(reset),
    .cond_in(oper_cond & `OSF_LIVE_MASK),
    .enable_r(oper_enable),
    .event_read(oper_event_read),
    .event_clear(oper_event_clear),
    .cond_out(operation_condition),
    .event_out(operation_event),
    .summary(oper_sum)
  );

  osf_status_group u_ques (
    .clk_sys(clk_sys),
    .reset(reset),
    .cond_in(16'h0000), // RULE9
    .enable_r(ques_enable),
    .event_read(ques_event_read),
    .event_clear(ques_event_clear),
    .cond_out(ques_condition),
    .event_out(ques_event),
    .summary(ques_sum)
  );

  always_comb begin
    stb_summary = 8'h00;
    stb_summary[`OSF_SUM_OPER_BIT] = oper_sum; // RULE4
    stb_summary[`OSF_SUM_QUES_BIT] = ques_sum; // RULE4
  end
endmodule

/* File: include/osf_map.svh */
// constants for the operation status and trigger sequencer block
// assumes one 20 MHz clock and a command front end that pulses strobes
// Contract
// [RULE1] condition bits follow live internal states exactly
// [RULE2] event bit sets on condition fall, bits 8 and 9 on rise
// [RULE3] event bits stay set until the register is read or cleared
// [RULE4] enabled event bits drive summary: operation bit 7, questionable bit 3
// [RULE5] condition bit 8 high while data buffer full; bits 9-15 and 3 zero
// [RULE6] bit 7 high during correction measurement; bit 4 while measuring
// [RULE7] bit 6 high in ARM detection; bit 5 high in TRIG detection
// [RULE8] bit 2 ranging, bit 1 settling, bit 0 calibrating
// [RULE9] questionable group always reads zero
// [RULE10] power-on idle; abort or reset forces idle; reset clears continuous
// [RULE11] idle until immediate initiate or continuous on, then initiate
// [RULE12] initiate passes down; upward goes to TRIG if continuous else idle
// [RULE13] non-immediate ARM source waits, then voltage-on and wait sub-states
// [RULE14] ARM and TRIG delays waited after event; reset zeroes both
// [RULE15] all ARM conditions met before any TRIG event is sensed
// [RULE16] TRIG source selects the input that releases TRIG detection
// [RULE17] trigger-immediate skips TRIG detection and delay for one pass
// [RULE18] trigger count sets downward exits before upward; reset sets 1
// [RULE19] sequence entry starts a measurement; exit waits for completion
// [RULE20] controller supplies events by bus trigger or external pulse
// [RULE21] bus trigger common command counts as ARM only when source is bus
// [RULE22] summary is OR of enabled event bits, same cycle
`ifndef OSF_MAP_SVH
`define OSF_MAP_SVH
`define OSF_BIT_CAL 0
`define OSF_BIT_SETTLE 1
`define OSF_BIT_RANGE 2
`define OSF_BIT_MEAS 4
`define OSF_BIT_WTRIG 5
`define OSF_BIT_WARM 6
`define OSF_BIT_CORR 7
`define OSF_BIT_BUFFULL 8
`define OSF_BIT_RISE9 9
`define OSF_SUM_OPER_BIT 7
`define OSF_SUM_QUES_BIT 3
`define OSF_COND_RESET 16'h0000
`define OSF_RISE_MASK 16'h0300
`define OSF_LIVE_MASK 16'h01F7
`define OSF_DELAY_RESET 24'h000000
`define OSF_COUNT_RESET 16'h0001
`define OSF_VON_CYCLES 4'h2
`define OSF_WAIT_CYCLES 4'h2
`endif

/* File: include/osf_pkg.sv */
// types of the operation status and trigger sequencer block
// assumes osf_map.svh supplies the numbers
package osf_pkg;
  typedef enum logic [1:0] {
    OSF_SRC_BUS,
    OSF_SRC_EXT,
    OSF_SRC_MAN,
    OSF_SRC_IMM
  } osf_src_t;
  typedef enum logic [3:0] {
    OSF_IDLE,
    OSF_INIT,
    OSF_ARM_DET,
    OSF_ARM_DLY,
    OSF_VOLT_ON,
    OSF_ARM_WAIT,
    OSF_TRIG_DET,
    OSF_TRIG_DLY,
    OSF_SEQ_OP
  } osf_state_t;
  typedef struct packed {
    logic data_buffer_full;
    logic correcting;
    logic ranging;
    logic settling;
    logic calibrating;
  } osf_stat_t;
  typedef struct packed {
    osf_src_t arm_src;
    osf_src_t trig_src;
    logic [23:0] arm_delay;
    logic [23:0] trig_delay;
    logic [15:0] trig_count;
  } osf_cfg_t;
endpackage

/* File: hw/osf_status_group.sv */
// one condition/event/enable status group with transition filter
// assumes condition input is already synchronous to clk_sys
`timescale 1ns/1ps
`include "osf_map.svh"
module osf_status_group (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] cond_in,
  input wire logic [15:0] enable_r,
  input wire logic event_read,
  input wire logic event_clear,
  output logic [15:0] cond_out,
  output logic [15:0] event_out,
  output logic summary
);
  logic [15:0] cond_r;
  logic [15:0] event_r;
  logic [15:0] hit;
  // ----------------------------------------
  // transition filter
  // ----------------------------------------
  always_comb begin
    hit = (cond_r & ~cond_in & ~`OSF_RISE_MASK) | (~cond_r & cond_in & `OSF_RISE_MASK); // RULE2
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cond_r <= `OSF_COND_RESET;
    end else begin
      cond_r <= cond_in; // RULE1
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      event_r <= `OSF_COND_RESET;
    end else if (event_read || event_clear) begin
      event_r <= hit; // RULE3
    end else begin
      event_r <= event_r | hit; // RULE3
    end
  end
  assign cond_out = cond_r;
  assign event_out = event_r;
  assign summary = |(event_r & enable_r); // RULE22
endmodule

/* File: sim/osf_props.sv */
// port assertions for the trigger sequencer
// assumes a bind onto osf_trigger_fsm, one clock domain
`timescale 1ns/1ps
module osf_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_abort,
  input wire logic [15:0] oper_enable,
  input wire logic oper_event_read,
  input wire logic oper_event_clear,
  input wire logic meas_start,
  input wire logic volt_on,
  input wire logic [15:0] operation_condition,
  input wire logic [15:0] operation_event,
  input wire logic [15:0] ques_condition,
  input wire logic [15:0] ques_event,
  input wire logic [7:0] stb_summary
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_ques_zero: assert property (ques_condition == 16'h0000 && ques_event == 16'h0000
    && stb_summary[3] == 1'b0) else $error("questionable group not zero");
  chk_fixed_zero: assert property (operation_condition[15:9] == 7'h00 && !operation_condition[3])
    else $error("reserved condition bit set");
  chk_summary_or: assert property (stb_summary[7] == |(operation_event & oper_enable))
    else $error("operation summary wrong");
  chk_fall_event: assert property ($fell(operation_condition[4]) |=> operation_event[4])
    else $error("fall not reported");
  chk_rise_event: assert property ($rose(operation_condition[8]) |=> operation_event[8])
    else $error("rise not reported");
  chk_event_hold: assert property (operation_event[4] && !oper_event_read && !oper_event_clear
    |=> operation_event[4]) else $error("event lost");
  chk_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start pulse too long");
  chk_start_meas: assert property (meas_start |=> operation_condition[4])
    else $error("measuring bit missing");
  chk_abort_idle: assert property (cmd_abort |=> ##1 operation_condition[6:5] == 2'h0)
    else $error("abort left detection");
  cov_start: cover property (meas_start);
  cov_volt: cover property ($rose(volt_on));
  cov_full: cover property ($rose(operation_event[8]));
endmodule

/* File: sim/osf_meas_model.sv */
// measurement hardware and trigger source beside the sequencer
// assumes meas_start is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module osf_meas_model #(parameter int LAT = 4) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic meas_start,
  input wire logic fire,
  output logic meas_done,
  output logic ext_trig_pin
);
  int cnt;
  int hold;
  // done pulse a fixed time after each start
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (cnt == 1);
      cnt <= meas_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
  end
  // external trigger pulse, three cycles wide
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hold <= 0;
    end else begin
      hold <= fire ? 3 : (hold > 0 ? hold - 1 : 0);
    end
  end
  assign ext_trig_pin = (hold > 0);
endmodule

/* File: sim/operation_status_and_trigger_fsm_test.sv */
// self-checking bench for the trigger sequencer
// assumes osf_pkg is compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module operation_status_and_trigger_fsm_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic fire = 1'b0;
  logic man = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  osf_pkg::osf_cfg_t cfg_in = '0;
  osf_pkg::osf_stat_t stat_pin = '0;
  logic [15:0] oen = 16'h0010;
  wire meas_start, volt_on, meas_done, ext_trig_pin;
  wire [15:0] oc, oe;
  wire [7:0] stb;
  int err_total = 0;
  int checked = 0;
  int starts = 0;
  int cyc = 0;
  int s;
  int c0;
  osf_trigger_fsm dut (.clk_sys, .reset, .cmd_abort(cmd[0]), .cmd_rst(cmd[1]), .cmd_init_imm(cmd[2]),
    .cmd_cont_on(cmd[3]), .cmd_cont_off(cmd[4]), .cmd_bus_trg(cmd[5]), .cmd_trig_imm(cmd[6]),
    .cmd_cfg_wr(cmd[7]), .cfg_in, .ext_trig_pin, .man_trig_pin(man), .stat_pin, .meas_done,
    .oper_enable(oen), .ques_enable(16'hFFFF), .oper_event_read(rd), .oper_event_clear(clr),
    .ques_event_read(1'b0), .ques_event_clear(1'b0), .meas_start, .volt_on,
    .operation_condition(oc), .operation_event(oe), .ques_condition(), .ques_event(), .stb_summary(stb));
  osf_meas_model mdl (.clk_sys, .reset, .meas_start, .fire, .meas_done, .ext_trig_pin);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (meas_start === 1'b1) starts <= starts + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys) cmd <= 8'h01 << k;
    @(posedge clk_sys) cmd <= 8'h00;
  endtask
  task automatic ws(input int n);
    for (int i = 0; i < 400 && starts < n; i++) @(posedge clk_sys);
    wc(1);
  endtask
  task automatic setc(input osf_pkg::osf_src_t a, input osf_pkg::osf_src_t t, input int td, input int n);
    cfg_in <= '{a, t, 24'h000000, td[23:0], n[15:0]};
    pulse(7);
    @(posedge clk_sys) rd <= 1'b1;
    @(posedge clk_sys) rd <= 1'b0;
    s = starts;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_single();
    setc(osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, 0, 1);
    pulse(2);
    ws(s + 1);
    `CHK("no volt", 1'b0, volt_on)
    wc(10);
    `CHK("starts", s + 1, starts)
    `CHK("idle", 16'h0000, oc)
    `CHK("events", 16'h0070, oe)
    `CHK("summary", 8'h80, stb)
    @(posedge clk_sys) rd <= 1'b1;
    @(posedge clk_sys) rd <= 1'b0;
    wc(1);
    `CHK("read", 16'h0000, oe)
    $display("single done");
  endtask
  task automatic t_arm();
    setc(osf_pkg::OSF_SRC_EXT, osf_pkg::OSF_SRC_IMM, 0, 1);
    pulse(2);
    wc(6);
    `CHK("arm wait", 1'b1, oc[6])
    pulse(5);
    wc(8);
    `CHK("bus ignored", s, starts)
    @(posedge clk_sys) fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
    ws(s + 1);
    `CHK("ext start", s + 1, starts)
    `CHK("volt", 1'b1, volt_on)
    wc(10);
    setc(osf_pkg::OSF_SRC_BUS, osf_pkg::OSF_SRC_IMM, 0, 1);
    pulse(2);
    wc(6);
    pulse(5);
    ws(s + 1);
    `CHK("bus start", s + 1, starts)
    wc(10);
    $display("arm done");
  endtask
  task automatic t_trig();
    setc(osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_BUS, 0, 1);
    pulse(2);
    wc(6);
    `CHK("trig wait", 1'b1, oc[5])
    pulse(5);
    ws(s + 1);
    `CHK("bus trig", s + 1, starts)
    wc(10);
    pulse(6);
    pulse(2);
    ws(s + 2);
    `CHK("trig imm", s + 2, starts)
    wc(10);
    pulse(2);
    wc(20);
    `CHK("one pass", s + 2, starts)
    pulse(0);
    wc(3);
    $display("trig done");
  endtask
  task automatic t_count();
    setc(osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, 30, 3);
    c0 = cyc;
    pulse(2);
    ws(s + 3);
    `CHK("delay", 1'b1, (cyc - c0) > 90)
    wc(20);
    `CHK("count", s + 3, starts)
    $display("count done");
  endtask
  task automatic t_cont();
    setc(osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, 0, 1);
    pulse(3);
    ws(s + 3);
    `CHK("loop", s + 3, starts)
    pulse(1);
    wc(12);
    s = starts;
    wc(20);
    `CHK("stopped", s, starts)
    `CHK("idle", 16'h0000, oc)
    $display("cont done");
  endtask
  task automatic t_man();
    cfg_in <= '{osf_pkg::OSF_SRC_MAN, osf_pkg::OSF_SRC_IMM, 24'h000028, 24'h000000, 16'h0001};
    pulse(7);
    s = starts;
    pulse(3);
    wc(10);
    `CHK("man wait", 1'b1, oc[6])
    `CHK("man held", s, starts)
    @(posedge clk_sys) man <= 1'b1;
    c0 = cyc;
    wc(3);
    @(posedge clk_sys) man <= 1'b0;
    ws(s + 1);
    `CHK("arm delay", 1'b1, (cyc - c0) > 40)
    pulse(4);
    wc(20);
    s = starts;
    wc(20);
    `CHK("cont off", s, starts)
    `CHK("volt off", 1'b0, volt_on)
    $display("man done");
  endtask
  task automatic t_stat();
    setc(osf_pkg::OSF_SRC_IMM, osf_pkg::OSF_SRC_IMM, 0, 1);
    stat_pin <= 5'h1F;
    wc(6);
    `CHK("cond", 16'h0187, oc)
    `CHK("rise", 16'h0100, oe)
    stat_pin <= 5'h00;
    wc(6);
    `CHK("falls", 16'h0187, oe)
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
    wc(1);
    `CHK("clear", 16'h0000, oe)
    $display("stat done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    wc(2);
    `CHK("reset cond", 16'h0000, oc)
    `CHK("reset stb", 8'h00, stb)
    t_single();
    t_arm();
    t_trig();
    t_count();
    t_cont();
    t_man();
    t_stat();
    finish_test();
  end
endmodule
bind osf_trigger_fsm osf_props u_props (.clk_sys, .reset, .cmd_abort, .oper_enable, .oper_event_read,
  .oper_event_clear, .meas_start, .volt_on, .operation_condition, .operation_event, .ques_condition,
  .ques_event, .stb_summary);
